// *** smt_status_regs.svh ***
// offsets, field positions, reset values and timing counts of the monitor status word
// Operation
// - one status word written per recorded message
// - extended bits only when config bit 2 set
// - end flag set at message end, errors or not
// - start flag cleared with end flag
// - start flag set 3-4 us after command
// - start flag returns low at message end
// - filtered-out messages never raise start flag
// - bus identifier 0 for A, 1 for B
// - superseded unfinished message sets error flag
// - gap, timeout, length errors set error flag
// - sync, invalid word, link errors set error flag
// - second command, content errors set error flag
// - second command subaddress 00000/11111 excused
// - same address, undefined receive mode excused
`ifndef MON_STATUS_REGS_SVH
`define MON_STATUS_REGS_SVH

`define MONITOR_CONFIG_OFFSET 16'h0029
`define MONITOR_EXT_STATUS_BIT 2
`define STATUS_WORD_RESET 16'h0000
`define STATUS_END_BIT 15
`define STATUS_BEGIN_BIT 14
`define STATUS_BUS_BIT 13
`define STATUS_ERROR_BIT 12
`define STATUS_RTRT_BIT 11
`define STATUS_GAP_BIT 10
`define STATUS_TIMEOUT_BIT 9
`define STATUS_LENGTH_BIT 5
`define STATUS_SYNC_BIT 4
`define STATUS_INVALID_BIT 3
`define STATUS_LINK_BIT 2
`define STATUS_CW2_BIT 1
`define STATUS_CONTENT_BIT 0
`define SUBADDR_MODE_LOW 5'h00
`define SUBADDR_MODE_HIGH 5'h1F
`define CLK_PERIOD_NS 20
`define BEGIN_DELAY_NS 3000
`define BEGIN_DELAY_CYCLES ((`BEGIN_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** smt_status_pkg.sv ***
// types shared by the monitor status word logic
package mon_status_pkg;

	// detailed error events reported by the message decoder, one-cycle pulses
	typedef struct packed {
		logic illegal_gap;
		logic resp_timeout;
		logic length_err;
		logic sync_err;
		logic invalid_word;
		logic rtrt_link_err;
		logic cw2_err;
		logic content_err;
	} err_events_t;

	// qualifiers that go with the second command and content error events
	typedef struct packed {
		logic [4:0] cw1_rt_addr;
		logic [4:0] cw2_rt_addr;
		logic [4:0] cw2_subaddr;
		logic rx_mode_undefined;
	} err_context_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT_BEGIN = 3'b010,
		ST_ACTIVE = 3'b100
	} msg_state_t;

endpackage

// *** error_merge.sv ***
// forms the error flag contribution of one cycle's error events
`timescale 1ns/1ps
`include "smt_status_regs.svh"
module error_merge
(
	input wire mon_status_pkg::err_events_t events,
	input wire mon_status_pkg::err_context_t context_in,
	output logic raise_error
);
	import mon_status_pkg::*;

	// a second command naming a mode code subaddress
	function automatic logic is_mode_subaddr(input logic [4:0] sa);
		is_mode_subaddr = (sa == `SUBADDR_MODE_LOW) || (sa == `SUBADDR_MODE_HIGH);
	endfunction

	wire cw2_excused;
	wire content_excused;
	wire plain_errors;

	// exception cases that record the detail bit but leave the error flag alone
	assign cw2_excused = is_mode_subaddr(context_in.cw2_subaddr)
		|| (context_in.cw2_rt_addr == context_in.cw1_rt_addr);
	assign content_excused = context_in.rx_mode_undefined;

	// unconditional error sources
	assign plain_errors = events.illegal_gap | events.resp_timeout | events.length_err
		| events.sync_err | events.invalid_word | events.rtrt_link_err;

	assign raise_error = plain_errors
		| (events.cw2_err & ~cw2_excused)
		| (events.content_err & ~content_excused);
endmodule

// *** monitor_block_status_word.sv ***
// builds and writes the per-message monitor status word
`timescale 1ns/1ps
`include "smt_status_regs.svh"
module monitor_block_status_word
(
	input wire clk,
	input wire rst,
	// pulse: a valid command word has been fully received
	input wire cmd_valid,
	// level with cmd_valid: command arrived on bus B
	input wire cmd_on_bus_b,
	// level with cmd_valid: filter selects this message
	input wire cmd_selected,
	// level with cmd_valid: message opens with two commands
	input wire cmd_is_rtrt,
	// pulse: monitored message completed
	input wire msg_done,
	// pulses: detailed error events of the open message
	input wire mon_status_pkg::err_events_t err_events,
	// levels: addresses and mode flag for the excused cases
	input wire mon_status_pkg::err_context_t err_context,
	// monitor configuration register contents
	input wire [15:0] monitor_config,
	// live status word of the message in progress
	output logic [15:0] status_word,
	// pulse: write status_data into the command buffer entry
	output logic status_wr,
	output logic [15:0] status_data
);
	import mon_status_pkg::*;

	// cycles from the taking edge of a command to the begin flag
	localparam logic [7:0] BEGIN_CYCLES = 8'(`BEGIN_DELAY_CYCLES);

	// registered message state
	msg_state_t state;
	msg_state_t next_state;
	logic [7:0] delay_count;
	logic begin_flag;
	logic end_flag;
	logic bus_id;
	logic error_flag;
	logic rtrt_flag;
	err_events_t detail;
	// the word handed to the command buffer
	logic wr_pulse;
	logic [15:0] wr_data;

	// decoded conditions and word fields
	wire raise_error;
	wire delay_restart;
	wire next_error;
	wire in_message;
	wire superseded;
	wire finishing;
	wire new_monitored;
	wire delay_done;
	wire ext_status;
	wire [11:0] ext_bits;
	wire [11:0] ext_bits_next;
	wire [15:0] live_word;
	wire [15:0] closing_word;
	err_events_t detail_merged;

	// error sources merged with their exceptions
	error_merge u_error_merge
	(
		.events(err_events),
		.context_in(err_context),
		.raise_error(raise_error)
	);

	// message tracking conditions
	assign in_message = (state == ST_WAIT_BEGIN) || (state == ST_ACTIVE);
	assign superseded = in_message && cmd_valid;
	assign finishing = in_message && (msg_done || cmd_valid);
	assign new_monitored = cmd_valid && cmd_selected;
	assign delay_done = (state == ST_WAIT_BEGIN) && (delay_count == BEGIN_CYCLES - 8'h01);
	assign ext_status = monitor_config[`MONITOR_EXT_STATUS_BIT];
	assign delay_restart = (next_state == ST_WAIT_BEGIN && state != ST_WAIT_BEGIN)
		|| cmd_valid;

	// detail bits including any event arriving in the closing cycle
	assign detail_merged = detail | err_events;
	// a filtered command that cuts a message marks the live word as well
	assign next_error = error_flag | raise_error | superseded;

	// extended field layout for a given set of detail bits
	function automatic logic [11:0] pack_ext(input err_events_t d, input logic rr);
		logic [11:0] v;
		v = 12'h000;
		v[`STATUS_RTRT_BIT] = rr;
		v[`STATUS_GAP_BIT] = d.illegal_gap;
		v[`STATUS_TIMEOUT_BIT] = d.resp_timeout;
		v[`STATUS_LENGTH_BIT] = d.length_err;
		v[`STATUS_SYNC_BIT] = d.sync_err;
		v[`STATUS_INVALID_BIT] = d.invalid_word;
		v[`STATUS_LINK_BIT] = d.rtrt_link_err;
		v[`STATUS_CW2_BIT] = d.cw2_err;
		v[`STATUS_CONTENT_BIT] = d.content_err;
		// bits 8 to 6 have no source here and stay zero
		pack_ext = v;
	endfunction

	// extended bits read as zero unless the option is enabled
	assign ext_bits = ext_status ? pack_ext(detail, rtrt_flag) : 12'h000;
	assign ext_bits_next = ext_status ? pack_ext(detail_merged, rtrt_flag) : 12'h000;

	// live word straight from the flags
	assign live_word = {end_flag, begin_flag, bus_id, error_flag, ext_bits};

	// final word: end set, begin cleared, error folds in closing-cycle events
	assign closing_word = {1'b1,
		1'b0,
		bus_id,
		error_flag | raise_error | superseded,
		ext_bits_next};

	// next state of the message tracker
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_IDLE:
			begin
				if (new_monitored)
					next_state = ST_WAIT_BEGIN;
			end
			ST_WAIT_BEGIN, ST_ACTIVE:
			begin
				if (cmd_valid)
					next_state = cmd_selected ? ST_WAIT_BEGIN : ST_IDLE;
				else if (msg_done)
					next_state = ST_IDLE;
				else if (delay_done)
					next_state = ST_ACTIVE;
			end
			default:
				next_state = ST_IDLE;
		endcase
	end

	// state and begin delay counter
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
			delay_count <= 8'h00;
		end
		else
		begin
			state <= next_state;
			delay_count <= delay_restart ? 8'h00 : delay_count + 8'h01;
		end
	end

	// start and end flags of the live word
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			begin_flag <= 1'b0;
			end_flag <= 1'b0;
		end
		else if (new_monitored)
		begin
			begin_flag <= 1'b0;
			end_flag <= 1'b0;
		end
		else if (finishing)
		begin
			begin_flag <= 1'b0;
			end_flag <= 1'b1;
		end
		else if (delay_done)
			begin_flag <= 1'b1;
	end

	// per-message identity and accumulated errors; a restart clears the old message's errors
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bus_id <= 1'b0;
			rtrt_flag <= 1'b0;
			error_flag <= 1'b0;
			detail <= '0;
		end
		else if (new_monitored)
		begin
			bus_id <= cmd_on_bus_b;
			rtrt_flag <= cmd_is_rtrt;
			error_flag <= 1'b0;
			detail <= '0;
		end
		else if (in_message)
		begin
			error_flag <= next_error;
			detail <= detail_merged;
		end
	end

	// single command buffer write as each monitored message closes
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_pulse <= 1'b0;
			wr_data <= `STATUS_WORD_RESET;
		end
		else
		begin
			wr_pulse <= finishing;
			if (finishing)
				wr_data <= closing_word;
		end
	end

	// write outputs straight from flip-flops; live word from the flags, its extended bits gated by monitor_config bit 2
	assign status_word = live_word;
	assign status_wr = wr_pulse;
	assign status_data = wr_data;
endmodule

// *** mbsw_asserts.sv ***
// port checks of the monitor status word block
`timescale 1ns/1ps
module mbsw_asserts
(
	input wire clk,
	input wire rst,
	input wire cmd_valid,
	input wire cmd_on_bus_b,
	input wire cmd_selected,
	input wire msg_done,
	input wire mon_status_pkg::err_events_t err_events,
	input wire [15:0] monitor_config,
	input wire [15:0] status_word,
	input wire status_wr,
	input wire [15:0] status_data
);
	import mon_status_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [7:0] since_cmd;
	// cycles since the last selected command, held at its ceiling
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			since_cmd <= 8'h00;
		else if (cmd_valid && cmd_selected)
			since_cmd <= 8'h01;
		else if (since_cmd != 8'hFF)
			since_cmd <= since_cmd + 8'h01;
	end
	// written word and live flags
	chk_one_write: assert property (status_wr |=> !status_wr)
		else $error("write pulse too long");
	chk_end_flag: assert property (status_wr |-> status_data[15]
		&& (status_word[15] || $past(cmd_valid && cmd_selected)))
		else $error("end flag missing");
	chk_begin_drop: assert property (status_wr |-> !status_data[14] && !status_word[14])
		else $error("begin flag not cleared");
	chk_begin_wait: assert property (cmd_valid && cmd_selected |=> !status_word[14] [*8])
		else $error("begin flag early");
	chk_begin_time: assert property ($rose(status_word[14]) |-> since_cmd >= 8'h97
		&& since_cmd <= 8'hC9)
		else $error("begin flag outside its delay window");
	chk_filter_quiet: assert property (cmd_valid && !cmd_selected |=> !status_word[14] [*8])
		else $error("begin flag on filtered command");
	chk_bus_id: assert property (cmd_valid && cmd_selected |=>
		status_word[13] == $past(cmd_on_bus_b))
		else $error("bus id wrong");
	chk_supersede_error: assert property (status_wr && $past(cmd_valid)
		&& !$past(msg_done) |-> status_data[12])
		else $error("superseded word lacks error");
	chk_error_or: assert property (status_wr && $past(msg_done)
		&& |$past(err_events[7:2]) |-> status_data[12])
		else $error("error flag missing");
	chk_ext_off: assert property (status_wr && !monitor_config[2]
		&& $stable(monitor_config) |-> status_data[11:0] == 12'h000)
		else $error("extended bits with option off");
	// main scenarios
	cover property (status_wr && status_data[12]);
	cover property (status_word[14]);
	cover property (status_wr && !monitor_config[2]);
endmodule
bind monitor_block_status_word mbsw_asserts u_mbsw_asserts (.clk, .rst, .cmd_valid,
	.cmd_on_bus_b, .cmd_selected, .msg_done, .err_events, .monitor_config, .status_word,
	.status_wr, .status_data);

// *** bus_source.sv ***
// far side model: decoder pulses for commands, message ends and errors
`timescale 1ns/1ps
module bus_source
(
	input wire clk,
	input wire rst,
	input wire [1:0] op,
	input wire mon_status_pkg::err_events_t ev,
	output logic cmd_valid,
	output logic msg_done,
	output mon_status_pkg::err_events_t err_events
);
	import mon_status_pkg::*;
	// one-cycle pulses, errors aligned with the message end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			{cmd_valid, msg_done, err_events} <= 10'h000;
		else
			{cmd_valid, msg_done, err_events} <= {op, ev};
	end
endmodule

// *** monitor_block_status_word_bench.sv ***
// self-checking bench for the monitor status word
`timescale 1ns/1ps
module monitor_block_status_word_bench;
	import mon_status_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] op = 2'b00;
	err_events_t ev = '0;
	logic bus_b = 1'b0;
	logic sel = 1'b1;
	logic rtrt = 1'b0;
	err_context_t ctx = '0;
	logic [15:0] cfg = 16'h0004;
	logic cmd_valid, msg_done, wr;
	err_events_t err_events;
	logic [15:0] word, data;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	always #10 clk = ~clk;
	bus_source u_bus_source (.clk, .rst, .op, .ev, .cmd_valid, .msg_done, .err_events);
	monitor_block_status_word u_monitor_block_status_word (.clk, .rst, .cmd_valid,
		.cmd_on_bus_b(bus_b), .cmd_selected(sel), .cmd_is_rtrt(rtrt), .msg_done,
		.err_events, .err_context(ctx), .monitor_config(cfg), .status_word(word),
		.status_wr(wr), .status_data(data));
	// compare one result
	task chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one decoder event, returns when its answer is visible
	task pulse(input logic [1:0] o, input err_events_t e);
		@(posedge clk) op <= o;
		ev <= e;
		@(posedge clk) op <= 2'b00;
		ev <= '0;
		@(posedge clk) #1;
	endtask
	// a whole message and its written word
	task msg(input err_events_t e, input logic [15:0] exp);
		pulse(2'b10, '0);
		pulse(2'b01, e);
		chk({15'h0000, wr}, 16'h0001);
		chk(data, exp);
	endtask
	// bus B, begin delay, timeout at close
	task t_walk;
		@(posedge clk) bus_b <= 1'b1;
		pulse(2'b10, '0);
		chk(word, 16'h2000);
		repeat (148) @(posedge clk);
		#1 chk({15'h0000, word[14]}, 16'h0000);
		repeat (2) @(posedge clk);
		#1 chk({15'h0000, word[14]}, 16'h0001);
		pulse(2'b01, 8'h40);
		chk({15'h0000, wr}, 16'h0001);
		chk(data, 16'hB200);
		chk(word, 16'hB200);
	endtask
	// extended bits off, length error still flags
	task t_ext_off;
		@(posedge clk) cfg <= 16'h0000;
		bus_b <= 1'b0;
		msg(8'h20, 16'h9000);
		@(posedge clk) cfg <= 16'h0004;
	endtask
	// a second command cuts an open message short
	task t_supersede;
		pulse(2'b10, '0);
		@(posedge clk) bus_b <= 1'b1;
		rtrt <= 1'b1;
		pulse(2'b10, '0);
		chk({15'h0000, wr}, 16'h0001);
		chk(data, 16'h9000);
		pulse(2'b01, '0);
		chk(data, 16'hA800);
	endtask
	// filtered command closes an open message, then stays silent; stray end ignored
	task t_filter;
		pulse(2'b10, '0);
		@(posedge clk) sel <= 1'b0;
		pulse(2'b10, '0);
		chk({15'h0000, wr}, 16'h0001);
		chk(data, 16'hB800);
		chk(word, 16'hB800);
		repeat (160) @(posedge clk);
		#1 chk({15'h0000, word[14]}, 16'h0000);
		pulse(2'b01, '0);
		chk({15'h0000, wr}, 16'h0000);
		@(posedge clk) sel <= 1'b1;
		bus_b <= 1'b0;
		rtrt <= 1'b0;
	endtask
	// each error source and the excused cases
	task t_errors;
		logic [7:0] e [12] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
			8'h02, 8'h02, 8'h02, 8'h02, 8'h01, 8'h01};
		logic [15:0] c [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
			16'h0880, 16'h08BE, 16'h084A, 16'h088A, 16'h0001, 16'h0000};
		logic [15:0] x [12] = '{16'h9400, 16'h9200, 16'h9020, 16'h9010, 16'h9008, 16'h9004,
			16'h8002, 16'h8002, 16'h8002, 16'h9002, 16'h8001, 16'h9001};
		for (int i = 0; i < 12; i++)
		begin
			@(posedge clk) ctx <= c[i];
			msg(e[i], x[i]);
		end
	endtask
	// main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_walk;
		t_ext_off;
		t_supersede;
		t_filter;
		t_errors;
		print_verdict;
	end
	// hang guard
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			mismatches++;
			print_verdict;
		end
	end
endmodule
